// File: core/ssw_pkg.sv
// Shared constants and carrier types for the serial-side word interface.
package ssw_pkg;
   localparam int LANES              = 4;
   localparam int LANE_W             = 8;
   localparam int WORD_W             = LANES * LANE_W;
   localparam int STAT_W             = 16;
   localparam int STAT_DISPERR_BIT   = 5;
   localparam int STAT_NOTINTAB_BIT  = 6;
   localparam int SYNC_STAGES        = 2;
   localparam int CORE_CLK_MHZ       = 100;
   localparam int LINK_CLK_MHZ       = 125;
   localparam logic RESET_ASSERTED   = 1'b1;
   localparam logic SYNC_RESET_VALUE = 1'b0;

   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic [LANES-1:0]  comma;
      logic [LANES-1:0]  ctrl;
      logic [LANES-1:0]  disperr;
      logic [LANES-1:0]  notintable;
      logic [LANES-1:0]  rundisp;
   } ssw_rx_s;

   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic [LANES-1:0]  ctrl;
      logic [LANES-1:0]  dispmode;
      logic [LANES-1:0]  dispval;
   } ssw_tx_s;

   typedef logic [LANES-1:0][STAT_W-1:0] ssw_status_t;

   typedef enum logic [1:0] {
      SSW_HOLD,
      SSW_WAIT_DONE,
      SSW_READY
   } ssw_rst_e;
endpackage

// File: core/ssw_sync.sv
// Multi-bit two-stage synchroniser for inputs from outside the core clock domain.
`timescale 1ns/100ps
module ssw_sync
   import ssw_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         core_clk, // Core clock.
   input  wire logic         rst_n,    // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,        // Asynchronous input.
   output logic      [W-1:0] q         // Synchronised output.
);
   logic [W-1:0] stage [SYNC_STAGES];

   genvar g;
   generate
      for (g = 0; g < SYNC_STAGES; g++)
      begin : g_stage
         // The first stage is split off so that no stage ever indexes below zero.
         if (g == 0)
         begin : g_first
            always_ff @(posedge core_clk or negedge rst_n)
            begin
               if (!rst_n)
                  stage[g] <= {W{SYNC_RESET_VALUE}};
               else
                  stage[g] <= d;
            end
         end
         else
         begin : g_next
            always_ff @(posedge core_clk or negedge rst_n)
            begin
               if (!rst_n)
                  stage[g] <= {W{SYNC_RESET_VALUE}};
               else
                  stage[g] <= stage[g-1];
            end
         end
      end
   endgenerate

   assign q = stage[SYNC_STAGES-1];
endmodule

// File: core/ssw_top.sv
// Physical-side word interface between the PCS core and the serial transceiver.
// Function
// - Receive reset output follows hard reset, soft reset or receive buffer error.
// - Transmit reset output follows hard reset, soft reset or transmit buffer error.
// - Both transceiver resets stay asserted while clock lock is low.
// - Receive word and flags are sampled on the recovered receive clock.
// - Transmit word and controls are timed on the reference clock; transmit buffer error reaches the transmit reset through the two-stage synchroniser.
// - Running disparity error of a lane appears on status bit 5.
// - Not-in-table code group of a lane appears on status bit 6.
`timescale 1ns/100ps
module ssw_top
   import ssw_pkg::*;
(
   input  wire logic        core_clk,                 // Core clock, 100 MHz.
   input  wire logic        rst_n,                    // Hard reset, async, active low.
   input  wire logic        soft_reset,               // Soft reset request, level.
   input  wire logic        rx_buf_err,               // Receive elastic buffer error, level.
   input  wire logic        clk_lock,                 // Clock synthesizer lock pin.
   input  wire logic        xcvr_reset_done,          // Transceiver reset-done pin.
   input  wire logic        rx_rec_clk,               // Recovered receive clock pin.
   input  wire logic        core_reference_clock_125, // Transmit reference clock pin.
   input  wire ssw_rx_s     rx_pins,                  // Receive word and flags from pins.
   input  wire logic        tx_buf_err,               // Transmit buffer error pin.
   input  wire ssw_tx_s     tx_in,                    // Transmit word from the core.
   input  wire logic        power_down_req,           // Power-down request from the core.
   input  wire logic        align_enable_req,         // Comma alignment request.
   output logic             xcvr_rx_reset,            // Receive path reset to transceiver.
   output logic             xcvr_tx_reset,            // Transmit path reset to transceiver.
   output logic             xcvr_ready,               // Transceiver out of reset.
   output ssw_tx_s          tx_pins,                  // Transmit word to pins.
   output logic             power_down,               // Power-down to transceiver.
   output logic             align_enable,             // Alignment enable to transceiver.
   output logic             tx_taken,                 // Pulse: tx_in was loaded.
   output ssw_rx_s          rx_word,                  // Captured receive word.
   output logic             rx_valid,                 // Pulse: rx_word updated.
   output ssw_status_t      status_ch                 // Per-lane status vectors.
);
   ssw_rx_s        rx_s;
   logic           rx_clk_s;
   logic           ref_clk_s;
   logic           tx_err_s;
   logic           lock_s;
   logic           done_s;
   logic           rx_clk_prev;
   logic           ref_clk_prev;
   logic           rx_rise;
   logic           tx_rise;
   ssw_rst_e       rst_state;
   ssw_rst_e       next_rst_state;
   logic           next_xcvr_rx_reset;
   logic           next_xcvr_tx_reset;
   logic           next_xcvr_ready;
   ssw_tx_s        next_tx_pins;
   logic           next_power_down;
   logic           next_align_enable;
   logic           next_tx_taken;
   ssw_rx_s        next_rx_word;
   logic           next_rx_valid;
   ssw_status_t    next_status_ch;

   // Receive clock and its data pass the same two stages, so they stay aligned.
   ssw_sync #(.W($bits(ssw_rx_s) + 1)) u_rx_sync
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        ({rx_rec_clk, rx_pins}),
      .q        ({rx_clk_s, rx_s})
   );

   ssw_sync #(.W(4)) u_ctl_sync
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        ({core_reference_clock_125, tx_buf_err, clk_lock, xcvr_reset_done}),
      .q        ({ref_clk_s, tx_err_s, lock_s, done_s})
   );

   assign rx_rise = rx_clk_s && !rx_clk_prev;
   assign tx_rise = ref_clk_s && !ref_clk_prev;

   // Reset sequencing toward the transceiver.
   always_comb
   begin
      next_xcvr_rx_reset = soft_reset || rx_buf_err || !lock_s;
      next_xcvr_tx_reset = soft_reset || tx_err_s || !lock_s;
      next_rst_state     = rst_state;
      case (rst_state)
         SSW_HOLD:
            if (!next_xcvr_rx_reset && !next_xcvr_tx_reset)
               next_rst_state = SSW_WAIT_DONE;
         SSW_WAIT_DONE:
            if (next_xcvr_rx_reset || next_xcvr_tx_reset)
               next_rst_state = SSW_HOLD;
            else if (done_s)
               next_rst_state = SSW_READY;
         SSW_READY:
            if (next_xcvr_rx_reset || next_xcvr_tx_reset || !done_s)
               next_rst_state = SSW_HOLD;
         default:
            next_rst_state = SSW_HOLD;
      endcase
      next_xcvr_ready = (next_rst_state == SSW_READY);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_state     <= SSW_HOLD;
         xcvr_rx_reset <= RESET_ASSERTED;
         xcvr_tx_reset <= RESET_ASSERTED;
         xcvr_ready    <= 1'b0;
      end
      else
      begin
         rst_state     <= next_rst_state;
         xcvr_rx_reset <= next_xcvr_rx_reset;
         xcvr_tx_reset <= next_xcvr_tx_reset;
         xcvr_ready    <= next_xcvr_ready;
      end
   end

   // Transmit side: tx_pins, power_down and align_enable change only on a reference clock edge.
   always_comb
   begin
      next_tx_pins      = tx_pins;
      next_power_down   = power_down;
      next_align_enable = align_enable;
      next_tx_taken     = 1'b0;
      if (tx_rise)
      begin
         next_tx_pins      = tx_in;
         next_power_down   = power_down_req;
         next_align_enable = align_enable_req;
         next_tx_taken     = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_clk_prev <= 1'b0;
         tx_pins      <= '0;
         power_down   <= 1'b0;
         align_enable <= 1'b0;
         tx_taken     <= 1'b0;
      end
      else
      begin
         ref_clk_prev <= ref_clk_s;
         tx_pins      <= next_tx_pins;
         power_down   <= next_power_down;
         align_enable <= next_align_enable;
         tx_taken     <= next_tx_taken;
      end
   end

   // Receive side: capture on a recovered clock edge and build lane status.
   always_comb
   begin
      next_rx_word   = rx_word;
      next_rx_valid  = 1'b0;
      next_status_ch = status_ch;
      if (rx_rise)
      begin
         next_rx_word  = rx_s;
         next_rx_valid = 1'b1;
         for (int i = 0; i < LANES; i++)
         begin
            next_status_ch[i]                    = '0;
            next_status_ch[i][STAT_DISPERR_BIT]  = rx_s.disperr[i];
            next_status_ch[i][STAT_NOTINTAB_BIT] = rx_s.notintable[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_clk_prev <= 1'b0;
         rx_word     <= '0;
         rx_valid    <= 1'b0;
         status_ch   <= '0;
      end
      else
      begin
         rx_clk_prev <= rx_clk_s;
         rx_word     <= next_rx_word;
         rx_valid    <= next_rx_valid;
         status_ch   <= next_status_ch;
      end
   end

   property p_rx_reset_src;
      @(posedge core_clk) disable iff (!rst_n)
      (soft_reset || rx_buf_err) |=> xcvr_rx_reset;
   endproperty
   a_rx_reset_src: assert property (p_rx_reset_src)
      else $error("receive reset not asserted for its source");

   property p_rx_release;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(xcvr_rx_reset) |-> (!$past(soft_reset) && !$past(rx_buf_err) && $past(lock_s));
   endproperty
   a_rx_release: assert property (p_rx_release)
      else $error("receive reset released while a source was active");

   property p_tx_reset_src;
      @(posedge core_clk) disable iff (!rst_n)
      (soft_reset || tx_err_s) |=> xcvr_tx_reset;
   endproperty
   a_tx_reset_src: assert property (p_tx_reset_src)
      else $error("transmit reset not asserted for its source");

   property p_lock_hold;
      @(posedge core_clk) disable iff (!rst_n)
      !lock_s |=> (xcvr_rx_reset && xcvr_tx_reset && !xcvr_ready);
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("transceiver not held in reset without lock");

   property p_ready_done;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(xcvr_ready) |-> ($past(done_s) && !xcvr_rx_reset && !xcvr_tx_reset);
   endproperty
   a_ready_done: assert property (p_ready_done)
      else $error("ready raised without reset done");

   property p_rx_capture;
      @(posedge core_clk) disable iff (!rst_n)
      rx_rise |=> (rx_valid && rx_word == $past(rx_s));
   endproperty
   a_rx_capture: assert property (p_rx_capture)
      else $error("receive word not captured on recovered clock edge");

   property p_rx_hold;
      @(posedge core_clk) disable iff (!rst_n)
      !rx_rise |=> (!rx_valid && $stable(rx_word));
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("receive word changed without a clock edge");

   property p_tx_edge;
      @(posedge core_clk) disable iff (!rst_n)
      tx_rise |=> (tx_taken && tx_pins == $past(tx_in) && power_down == $past(power_down_req));
   endproperty
   a_tx_edge: assert property (p_tx_edge)
      else $error("transmit outputs not loaded on reference edge");

   property p_tx_stable;
      @(posedge core_clk) disable iff (!rst_n)
      !tx_rise |=> ($stable(tx_pins) && $stable(align_enable) && !tx_taken);
   endproperty
   a_tx_stable: assert property (p_tx_stable)
      else $error("transmit outputs changed between reference edges");

   property p_disperr;
      @(posedge core_clk) disable iff (!rst_n)
      rx_valid |-> ({status_ch[3][STAT_DISPERR_BIT], status_ch[2][STAT_DISPERR_BIT],
                     status_ch[1][STAT_DISPERR_BIT], status_ch[0][STAT_DISPERR_BIT]}
                    == rx_word.disperr);
   endproperty
   a_disperr: assert property (p_disperr)
      else $error("disparity error status does not match lanes");

   property p_notintab;
      @(posedge core_clk) disable iff (!rst_n)
      rx_valid |-> ({status_ch[3][STAT_NOTINTAB_BIT], status_ch[2][STAT_NOTINTAB_BIT],
                     status_ch[1][STAT_NOTINTAB_BIT], status_ch[0][STAT_NOTINTAB_BIT]}
                    == rx_word.notintable);
   endproperty
   a_notintab: assert property (p_notintab)
      else $error("not-in-table status does not match lanes");
endmodule

// File: sim/ssw_xcvr_model.sv
// Behavioural transceiver model facing the serial-side word interface.
`timescale 1ns/100ps
module ssw_xcvr_model
   import ssw_pkg::*;
(
   input  wire logic xcvr_rx_reset, // Receive path reset.
   input  wire logic xcvr_tx_reset, // Transmit path reset.
   input  wire logic tx_err_cmd,    // Bench order to flag a buffer error.
   output logic      reset_done,    // Both paths out of reset.
   output logic      rec_clk,       // Recovered receive clock.
   output logic      ref_clk,       // Transmit reference clock.
   output logic      tx_buf_err,    // Transmit buffer error.
   output ssw_rx_s   rx_pins        // Receive word and flags.
);
   assign tx_buf_err = tx_err_cmd;

   initial
   begin
      reset_done = 1'b0;
      rec_clk = 1'b0;
      ref_clk = 1'b0;
      rx_pins = '0;
      #3.3;
      forever #40 ref_clk = ~ref_clk;
   end

   // Done rises only while both paths are out of reset and drops with either.
   always
   begin
      wait (!xcvr_rx_reset && !xcvr_tx_reset);
      #200;
      if (!xcvr_rx_reset && !xcvr_tx_reset)
      begin
         reset_done = 1'b1;
         wait (xcvr_rx_reset || xcvr_tx_reset);
      end
      reset_done = 1'b0;
   end

   // One receive period; the word is held 60 ns and then scrambled.
   task automatic rx_send(input ssw_rx_s w);
      #3.7;
      rec_clk = 1'b1;
      rx_pins = w;
      #40 rec_clk = 1'b0;
      #20 rx_pins = ~w;
      #16.3;
   endtask
endmodule

// File: sim/ssw_top_tb.sv
// Self-checking bench for the serial-side word interface.
`timescale 1ns/100ps
module ssw_top_tb
   import ssw_pkg::*;
;
   logic        core_clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, rx_buf_err = 1'b0;
   logic        clk_lock = 1'b0, tx_err_cmd = 1'b0, pd_req = 1'b0, al_req = 1'b0;
   logic        done, rec_clk, ref_clk, tx_buf_err, rx_rst, tx_rst, ready;
   logic        pd, al, tx_taken, rx_valid;
   ssw_rx_s     rx_pins, rx_word, rx_q[$];
   ssw_tx_s     tx_in = '0, tx_pins;
   ssw_status_t status_ch;
   logic [45:0] tx_q[$];
   int          n_errors = 0, n_tests = 0;

   always #5 core_clk = ~core_clk;

   ssw_top uut (.core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset),
      .rx_buf_err(rx_buf_err), .clk_lock(clk_lock), .xcvr_reset_done(done),
      .rx_rec_clk(rec_clk), .core_reference_clock_125(ref_clk), .rx_pins(rx_pins),
      .tx_buf_err(tx_buf_err), .tx_in(tx_in), .power_down_req(pd_req),
      .align_enable_req(al_req), .xcvr_rx_reset(rx_rst), .xcvr_tx_reset(tx_rst),
      .xcvr_ready(ready), .tx_pins(tx_pins), .power_down(pd), .align_enable(al),
      .tx_taken(tx_taken), .rx_word(rx_word), .rx_valid(rx_valid), .status_ch(status_ch));

   ssw_xcvr_model xm (.xcvr_rx_reset(rx_rst), .xcvr_tx_reset(tx_rst),
      .tx_err_cmd(tx_err_cmd), .reset_done(done), .rec_clk(rec_clk), .ref_clk(ref_clk),
      .tx_buf_err(tx_buf_err), .rx_pins(rx_pins));

   task automatic summarize;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic fail(input string what);
      n_errors++;
      $display("[FAIL] %0t %s", $time, what);
   endtask

   task automatic cmp_lvl(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp)
         fail(what);
   endtask

   task automatic cmp_rx(input ssw_rx_s exp);
      ssw_status_t st;
      st = '0;
      for (int i = 0; i < LANES; i++)
      begin
         st[i][STAT_DISPERR_BIT] = exp.disperr[i];
         st[i][STAT_NOTINTAB_BIT] = exp.notintable[i];
      end
      n_tests++;
      if (rx_word !== exp || status_ch !== st)
         fail("receive word or status");
   endtask

   task automatic cmp_tx(input logic [45:0] exp);
      n_tests++;
      if ({tx_pins, pd, al} !== exp)
         fail("transmit word");
   endtask

   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask

   task automatic wait_ready;
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 200)
      begin
         tick();
         k++;
      end
      if (ready !== 1'b1)
      begin
         fail("ready timeout");
         summarize();
      end
   endtask

   task automatic wait_taken;
      int k;
      k = 0;
      do
      begin
         @(negedge core_clk);
         k++;
      end
      while (tx_taken !== 1'b1 && k < 40);
      if (tx_taken !== 1'b1)
      begin
         fail("transmit timeout");
         summarize();
      end
   endtask

   always @(negedge core_clk)
   begin
      if (rx_valid === 1'b1)
      begin
         if (rx_q.size() == 0)
            fail("unexpected receive word");
         else
            cmp_rx(rx_q.pop_front());
      end
      if (tx_taken === 1'b1 && tx_q.size() > 0)
         cmp_tx(tx_q.pop_front());
   end

   initial
   begin
      ssw_rx_s w;
      void'($urandom(32'h63713704));
      repeat (3) tick();
      rst_n = 1'b1;
      repeat (10) tick();
      cmp_lvl(rx_rst & tx_rst & ~ready, 1'b1, "held without lock");
      clk_lock = 1'b1;
      wait_ready();
      cmp_lvl(rx_rst | tx_rst, 1'b0, "reset after lock");
      $display("lock test done");
      for (int s = 0; s < 4; s++)
      begin
         soft_reset = (s == 0);
         rx_buf_err = (s == 1);
         tx_err_cmd = (s == 2);
         clk_lock = (s != 3);
         repeat (5) tick();
         cmp_lvl(rx_rst, s != 2, "rx reset");
         cmp_lvl(tx_rst, s != 1, "tx reset");
         soft_reset = 1'b0;
         rx_buf_err = 1'b0;
         tx_err_cmd = 1'b0;
         clk_lock = 1'b1;
         wait_ready();
      end
      rst_n = 1'b0;
      repeat (3) tick();
      cmp_lvl(rx_rst & tx_rst & ~ready, 1'b1, "hard reset");
      rst_n = 1'b1;
      wait_ready();
      cmp_lvl(rx_rst | tx_rst, 1'b0, "reset after hard reset");
      $display("reset source test done");
      for (int n = 0; n < 14; n++)
      begin
         w = ssw_rx_s'(52'({$urandom, $urandom}));
         if (n == 0)
            w = '1;
         rx_q.push_back(w);
         xm.rx_send(w);
      end
      repeat (10) tick();
      cmp_lvl(rx_q.size() == 0, 1'b1, "receive words missing");
      $display("receive test done");
      for (int n = 0; n < 12; n++)
      begin
         wait_taken();
         tick();
         tx_in = ssw_tx_s'(44'({$urandom, $urandom}));
         pd_req = 1'($urandom);
         al_req = 1'($urandom);
         tx_q.push_back({tx_in, pd_req, al_req});
      end
      wait_taken();
      tick();
      cmp_lvl(tx_q.size() == 0, 1'b1, "transmit words missing");
      $display("transmit test done");
      summarize();
   end
endmodule
